// file: char_oled_fundamental_cmd_decoder.sv
// fundamental instruction decoder for a character oled driver
`timescale 1ns/1ps
// Overview of operation
// - clear: fill memory with spaces, counter to zero, cursor home, increment mode
// - home: counter to zero, cancel shift, memory untouched
// - direction high steps counter up, low steps down; glyph ram alike
// - auto-shift shifts enabled lines on character writes only
// - entry opcode loads direction/shift or common/segment direction by extension bit
// - segment direction low reverses segment order, high normal order
// - common direction low reverses common scan, high normal order
// - display-on bit lights display; off blanks but keeps memory
// - cursor-visible bit hides or shows cursor, direction kept
// - blink bit alternates cursor cell with all-lit pattern
// - font width high gives six-dot cells and six fifths execution time
// - six-dot mode draws glyph rows from bits five down to zero
// - inversion bit shows cursor inverted, ignoring visible and blink
// - wide line mode selects three/four line, else one/two line
// - shift opcode: cursor left/right with counter, or display shift
// - two-line mode wraps cursor to line two after position forty
// - four-line mode moves to next line after every twentieth position
// - display shift acts on each enabled line alone, counter kept
// - shift-type bit selects character shift or smooth dot scroll
// - locked interface refuses all commands unless oled set select is one
// - segment mapping from odd/even, remap and swap; default odd/even, no remap, no swap
// - extension enable steers shared opcodes to extended or basic bits
// - four line shift enables map to common groups of eight
// - line-count bit picks one/three or two/four line mode
module char_oled_fundamental_cmd_decoder
    import oled_cmd_pkg::*;
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    // host byte port
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    input  wire logic              data_sel_in,
    input  wire logic              glyph_access_in,
    input  wire logic [7:0]        wdata_in,
    input  wire logic              lock_in,
    input  wire logic              segment_remap_strap_in,
    input  wire logic              strap_use_in,
    input  wire logic [7:0]        exec_cycles_in,
    // glyph row formatting
    input  wire logic [7:0]        glyph_row_in,
    output logic [5:0]             glyph_pixels_out,
    // state
    output logic [ADDR_W-1:0]      address_counter_out,
    output logic [7:0]             rdata_out,
    output logic                   busy_out,
    output logic                   cmd_refused_out,
    output logic                   display_on_out,
    output logic                   cursor_on_out,
    output logic                   blink_on_out,
    output logic                   cursor_invert_out,
    output logic                   font_width_out,
    output logic                   wide_line_mode_out,
    output logic                   line_count_out,
    output logic                   common_direction_out,
    output logic                   segment_direction_out,
    output logic [2:0]             seg_map_case_out,
    output logic [NUM_LINES-1:0]   char_shift_lines_out,
    output logic [NUM_LINES-1:0]   dot_scroll_lines_out,
    output logic [4*6-1:0]         line_shift_out,
    output logic                   shift_left_pulse_out,
    output logic                   shift_right_pulse_out,
    output logic                   double_height_enable_out,
    output logic [1:0]             dbl_height_format_out,
    output logic                   clear_busy_out
);
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_CLEAR = 2'b10
    } state_e;

    state_e                  state;
    logic [7:0]              character_memory [MEM_DEPTH];
    logic [ADDR_W-1:0]       clear_ptr;
    logic [ADDR_W-1:0]       address_counter;
    logic                    addr_incr;
    logic                    auto_shift;
    logic                    special_set_select;
    logic                    extension_enable;
    logic                    oled_set_select;
    logic                    common_direction;
    logic                    segment_direction;
    logic                    font_width;
    logic                    wide_line_mode;
    logic                    line_count;
    logic                    display_on;
    logic                    cursor_on;
    logic                    blink_on;
    logic                    cursor_invert;
    logic                    double_height_enable;
    logic                    dbl_height_format_hi;
    logic                    dbl_height_format_lo;
    logic                    shift_type_select;
    logic [NUM_LINES-1:0]    line_shift_enable;
    logic [5:0]              line_shift [NUM_LINES];
    logic                    seg_oddeven;
    logic                    seg_swap;
    logic                    seg_cfg_pending;
    logic                    exec_busy;

    // byte classification
    function automatic logic op_match(input logic [7:0] b, input logic [7:0] m,
                                      input logic [7:0] v);
        op_match = (b & m) == v;
    endfunction : op_match

    // next counter value with line wrap
    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                    input logic up, input logic wide,
                                                    input logic two);
        logic [ADDR_W-1:0] col;
        logic [ADDR_W-1:0] len;
        logic [ADDR_W-1:0] base;
        len  = wide ? LINE_LEN_4 : LINE_LEN_2;
        base = wide ? (a & ~(LINE_STRIDE_4 - 7'h01)) : (a & LINE2_START);
        col  = a - base;
        if (!wide && !two) begin
            step_addr = up ? ((a >= (MEM_LAST - 7'h30)) ? ADDR_ZERO : a + 7'h01)
                           : ((a == ADDR_ZERO) ? 7'h4f : a - 7'h01);
        end else if (up) begin
            if (col + 7'h01 >= len) begin
                step_addr = base + (wide ? LINE_STRIDE_4 : LINE2_START);
            end else begin
                step_addr = a + 7'h01;
            end
        end else if (col == ADDR_ZERO) begin
            step_addr = base - (wide ? LINE_STRIDE_4 : LINE2_START) + len - 7'h01;
        end else begin
            step_addr = a - 7'h01;
        end
    endfunction : step_addr

    wire   cmd_write    = wr_in && !data_sel_in && !busy_out && (state == ST_IDLE);
    wire   lock_refuse  = lock_in && !oled_set_select;
    wire   cmd_ok       = cmd_write && !lock_refuse;
    wire   fund_ok      = cmd_ok && !oled_set_select;
    wire   is_clear     = fund_ok && (wdata_in == OP_CLEAR);
    wire   is_home      = fund_ok && op_match(wdata_in, MASK_HOME, OP_HOME) && !extension_enable;
    wire   is_entry     = fund_ok && op_match(wdata_in, MASK_ENTRY, OP_ENTRY);
    wire   is_disp      = fund_ok && op_match(wdata_in, MASK_DISP, OP_DISP);
    wire   is_shift     = fund_ok && op_match(wdata_in, MASK_SHIFT, OP_SHIFT);
    wire   is_func      = cmd_ok && op_match(wdata_in, MASK_FUNC, OP_FUNC);
    wire   is_seg_cfg   = cmd_ok && oled_set_select && (wdata_in == OP_SEG_CFG);
    wire   seg_arg      = cmd_ok && oled_set_select && seg_cfg_pending;
    wire   shift_cursor = is_shift && !special_set_select && !extension_enable && !wdata_in[3];
    wire   shift_disp   = is_shift && !special_set_select && !extension_enable && wdata_in[3];
    wire   dh_cmd       = is_shift && !special_set_select && extension_enable;
    wire   ena_cmd      = is_shift && special_set_select && extension_enable;
    wire   data_wr      = wr_in && data_sel_in && !busy_out && (state == ST_IDLE) && !lock_refuse;
    wire   data_rd      = rd_in && data_sel_in && (state == ST_IDLE);
    wire   character_memory_wr     = data_wr && !glyph_access_in;
    wire   auto_shift_go = character_memory_wr && auto_shift;
    wire   two_line     = line_count;
    wire [ADDR_W-1:0] next_step = step_addr(address_counter, addr_incr, wide_line_mode,
                                            two_line);
    wire [ADDR_W-1:0] next_cursor = step_addr(address_counter, wdata_in[2], wide_line_mode,
                                              two_line);
    wire   disp_go_left = shift_disp ? !wdata_in[2] : addr_incr;
    wire   disp_go      = shift_disp || auto_shift_go;
    wire   seg_remap    = strap_use_in ? segment_remap_strap_in : segment_direction;

    exec_timer u_exec_timer (
        .clk_in         (clk_in),
        .srst_in        (srst_in),
        .start_in       (cmd_ok || data_wr),
        .font_width_in  (font_width),
        .base_cycles_in (exec_cycles_in),
        .busy_out       (exec_busy)
    );

    // character memory and clear sequencer
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state     <= ST_IDLE;
            clear_ptr <= ADDR_ZERO;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (is_clear) begin
                        state     <= ST_CLEAR;
                        clear_ptr <= ADDR_ZERO;
                    end
                end
                ST_CLEAR: begin
                    clear_ptr <= clear_ptr + 7'h01;
                    if (clear_ptr == MEM_LAST) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (state == ST_CLEAR) begin
            character_memory[clear_ptr] <= SPACE_CODE;
        end else if (character_memory_wr) begin
            character_memory[address_counter] <= wdata_in;
        end
    end

    // address counter and entry mode
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            address_counter <= ADDR_ZERO;
            addr_incr       <= RST_DIR;
            auto_shift      <= 1'b0;
        end else if (is_clear) begin
            address_counter <= ADDR_ZERO;
            addr_incr       <= 1'b1;
        end else if (is_home) begin
            address_counter <= ADDR_ZERO;
        end else if (is_entry && !extension_enable) begin
            addr_incr  <= wdata_in[1];
            auto_shift <= wdata_in[0];
        end else if (shift_cursor) begin
            address_counter <= next_cursor;
        end else if (data_wr || data_rd) begin
            address_counter <= next_step;
        end
    end

    // mode bits
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            special_set_select   <= 1'b0;
            extension_enable     <= 1'b0;
            oled_set_select      <= 1'b0;
            common_direction     <= RST_DIR;
            segment_direction    <= RST_DIR;
            font_width           <= 1'b0;
            wide_line_mode       <= 1'b0;
            line_count           <= 1'b0;
            display_on           <= 1'b0;
            cursor_on            <= 1'b0;
            blink_on             <= 1'b0;
            cursor_invert        <= 1'b0;
            double_height_enable <= 1'b0;
            dbl_height_format_hi <= 1'b1;
            dbl_height_format_lo <= 1'b1;
            shift_type_select    <= 1'b1;
            line_shift_enable    <= '1;
            seg_oddeven          <= RST_SEG_ODDEVEN;
            seg_swap             <= RST_SEG_SWAP;
            seg_cfg_pending      <= 1'b0;
        end else begin
            if (cmd_ok && oled_set_select) begin
                seg_cfg_pending <= is_seg_cfg;
            end
            if (seg_arg) begin
                seg_oddeven <= wdata_in[BIT_SEG_OE];
                seg_swap    <= wdata_in[BIT_SEG_SW];
            end
            if (is_func) begin
                line_count       <= wdata_in[BIT_FUNC_N];
                extension_enable <= wdata_in[BIT_FUNC_RE];
                if (!wdata_in[BIT_FUNC_RE]) begin
                    double_height_enable <= wdata_in[BIT_FUNC_DH];
                    special_set_select   <= wdata_in[BIT_FUNC_IS];
                end else begin
                    oled_set_select <= 1'b0;
                end
            end
            if (cmd_ok && extension_enable && op_match(wdata_in, 8'hfe, 8'h78)) begin
                oled_set_select <= wdata_in[0];
            end
            if (is_entry && extension_enable) begin
                common_direction  <= wdata_in[1];
                segment_direction <= wdata_in[0];
            end
            if (is_disp && !extension_enable) begin
                display_on <= wdata_in[2];
                cursor_on  <= wdata_in[1];
                blink_on   <= wdata_in[0];
            end
            if (is_disp && extension_enable) begin
                font_width     <= wdata_in[2];
                cursor_invert  <= wdata_in[1];
                wide_line_mode <= wdata_in[0];
            end
            if (dh_cmd) begin
                dbl_height_format_hi <= wdata_in[3];
                dbl_height_format_lo <= wdata_in[2];
                shift_type_select    <= wdata_in[0];
            end
            if (ena_cmd) begin
                line_shift_enable <= wdata_in[3:0];
            end
        end
    end

    // per-line display shift
    genvar li;
    generate
        for (li = 0; li < NUM_LINES; li++) begin : g_line
            always_ff @(posedge clk_in) begin
                if (srst_in || is_home || is_clear) begin
                    line_shift[li] <= 6'h00;
                end else if (disp_go && line_shift_enable[li] && shift_type_select) begin
                    if (disp_go_left) begin
                        line_shift[li] <= (line_shift[li] == SHIFT_MAX) ? 6'h00
                                        : line_shift[li] + 6'h01;
                    end else begin
                        line_shift[li] <= (line_shift[li] == 6'h00) ? SHIFT_MAX
                                        : line_shift[li] - 6'h01;
                    end
                end
            end
        end
    endgenerate

    // registered outputs
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            address_counter_out      <= ADDR_ZERO;
            rdata_out                <= 8'h00;
            busy_out                 <= 1'b0;
            cmd_refused_out          <= 1'b0;
            display_on_out           <= 1'b0;
            cursor_on_out            <= 1'b0;
            blink_on_out             <= 1'b0;
            cursor_invert_out        <= 1'b0;
            font_width_out           <= 1'b0;
            wide_line_mode_out       <= 1'b0;
            line_count_out           <= 1'b0;
            common_direction_out     <= RST_DIR;
            segment_direction_out    <= RST_DIR;
            seg_map_case_out         <= 3'h4;
            char_shift_lines_out     <= 4'h0;
            dot_scroll_lines_out     <= 4'h0;
            line_shift_out           <= 24'h00_0000;
            shift_left_pulse_out     <= 1'b0;
            shift_right_pulse_out    <= 1'b0;
            double_height_enable_out <= 1'b0;
            dbl_height_format_out    <= 2'h3;
            clear_busy_out           <= 1'b0;
            glyph_pixels_out         <= 6'h00;
        end else begin
            address_counter_out   <= address_counter;
            rdata_out             <= data_rd ? character_memory[address_counter] : rdata_out;
            busy_out              <= exec_busy || (state == ST_CLEAR) || cmd_ok || data_wr;
            cmd_refused_out       <= cmd_write && lock_refuse;
            display_on_out        <= display_on;
            cursor_on_out         <= cursor_on && !cursor_invert;
            blink_on_out          <= blink_on && !cursor_invert;
            cursor_invert_out     <= cursor_invert;
            font_width_out        <= font_width;
            wide_line_mode_out    <= wide_line_mode;
            line_count_out        <= line_count;
            common_direction_out  <= common_direction;
            segment_direction_out <= seg_remap;
            seg_map_case_out      <= {seg_oddeven, !seg_remap, seg_swap};
            char_shift_lines_out  <= shift_type_select ? line_shift_enable : 4'h0;
            dot_scroll_lines_out  <= shift_type_select ? 4'h0 : line_shift_enable;
            line_shift_out        <= {line_shift[3], line_shift[2], line_shift[1], line_shift[0]};
            shift_left_pulse_out  <= disp_go && disp_go_left;
            shift_right_pulse_out <= disp_go && !disp_go_left;
            double_height_enable_out <= double_height_enable;
            dbl_height_format_out <= {dbl_height_format_hi, dbl_height_format_lo};
            clear_busy_out        <= (state == ST_CLEAR);
            glyph_pixels_out      <= font_width ? glyph_row_in[5:0]
                                               : {1'b0, glyph_row_in[4:0]};
        end
    end
endmodule : char_oled_fundamental_cmd_decoder

// file: exec_timer.sv
// execution time counter, stretched in six-dot font mode
`timescale 1ns/1ps
module exec_timer
    import oled_cmd_pkg::*;
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic srst_in,
    // control
    input  wire logic start_in,
    input  wire logic font_width_in,
    input  wire logic [7:0] base_cycles_in,
    // status
    output logic      busy_out
);
    logic [11:0] count;
    wire  [11:0] base_ext  = {4'h0, base_cycles_in};
    wire  [11:0] wide_len  = 12'((base_ext * 12'(WIDE_EXEC_CYC)) / 12'(BASE_EXEC_CYC));
    wire  [11:0] load_len  = font_width_in ? wide_len : base_ext;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count    <= 12'h000;
            busy_out <= 1'b0;
        end else if (start_in) begin
            count    <= load_len;
            busy_out <= 1'b1;
        end else if (count > 12'h001) begin
            count <= count - 12'h001;
        end else begin
            count    <= 12'h000;
            busy_out <= 1'b0;
        end
    end
endmodule : exec_timer

// file: host_model.sv
// host model that issues bytes and waits out busy
`timescale 1ns/1ps
module host_model (
    // clock and status
    input  wire logic  clk_in,
    input  wire logic  busy_in,
    // host byte port
    output logic       wr_out,
    output logic       dsel_out,
    output logic [7:0] byte_out
);
    initial begin
        wr_out = 1'b0;
        dsel_out = 1'b0;
        byte_out = 8'h00;
    end
    // one strobe, released byte inverted, bounded wait for idle
    task automatic send(input logic dc, input logic [7:0] b, output logic ok);
        int n;
        @(posedge clk_in);
        wr_out <= 1'b1;
        dsel_out <= dc;
        byte_out <= b;
        @(posedge clk_in);
        wr_out <= 1'b0;
        byte_out <= ~b;
        repeat (2) @(posedge clk_in);
        for (n = 0; n < 300 && busy_in !== 1'b0; n++) @(posedge clk_in);
        ok = (n < 300);
        #1;
    endtask : send
endmodule : host_model

// file: oled_cmd_checker_assertions.sv
// assertions on the command decoder ports
`timescale 1ns/1ps
module oled_cmd_checker
    import oled_cmd_pkg::*;
(
    // clock and reset
    input wire logic              clk_in,
    input wire logic              srst_in,
    // watched ports
    input wire logic              wr_in,
    input wire logic              data_sel_in,
    input wire logic              lock_in,
    input wire logic              busy_out,
    input wire logic              clear_busy_out,
    input wire logic              cmd_refused_out,
    input wire logic              display_on_out,
    input wire logic              font_width_out,
    input wire logic              shift_left_pulse_out,
    input wire logic              shift_right_pulse_out,
    input wire logic [ADDR_W-1:0] address_counter_out,
    input wire logic [7:0]        glyph_row_in,
    input wire logic [5:0]        glyph_pixels_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence cmd_taken;
        wr_in && !data_sel_in && !lock_in && !busy_out && !clear_busy_out;
    endsequence
    sequence ctr_hold;
        $stable(address_counter_out) [*2];
    endsequence
    busy_rise_a: assert property (cmd_taken |=> busy_out)
        else $error("busy did not rise after a command");
    busy_idle_a: assert property (!busy_out && !wr_in && !clear_busy_out |=> !busy_out)
        else $error("busy rose without a command");
    refuse_cause_a: assert property (cmd_refused_out |-> $past(lock_in) || $past(lock_in, 2))
        else $error("refusal without lock");
    shift_keeps_a: assert property ($rose(shift_left_pulse_out || shift_right_pulse_out)
        && !$past(data_sel_in) |-> ctr_hold)
        else $error("display shift moved the counter");
    glyph_six_a: assert property (font_width_out && $past(font_width_out)
        |-> glyph_pixels_out == $past(glyph_row_in[5:0]))
        else $error("six dot glyph row wrong");
    glyph_five_a: assert property (!font_width_out && !$past(font_width_out) && !$past(srst_in)
        |-> glyph_pixels_out == {1'b0, $past(glyph_row_in[4:0])})
        else $error("five dot glyph row wrong");
    clear_home_a: assert property ($fell(clear_busy_out) |-> address_counter_out == ADDR_ZERO)
        else $error("counter not zero after clear");
    disp_cause_a: assert property ($changed(display_on_out)
        |-> $past(wr_in) || $past(wr_in, 2) || $past(wr_in, 3))
        else $error("display state changed without a write");
endmodule : oled_cmd_checker
bind char_oled_fundamental_cmd_decoder oled_cmd_checker chk_u (.*);

// file: oled_cmd_pkg.sv
// constants for the character display fundamental command decoder
package oled_cmd_pkg;
    localparam int          ADDR_W          = 7;
    localparam logic [7:0]  SPACE_CODE      = 8'h20;
    localparam logic [6:0]  ADDR_ZERO       = 7'h00;
    localparam int          MEM_DEPTH       = 128;
    localparam logic [6:0]  MEM_LAST        = 7'h7f;
    localparam logic [6:0]  LINE2_START     = 7'h40;
    localparam logic [6:0]  LINE_LEN_2      = 7'h28;
    localparam logic [6:0]  LINE_LEN_4      = 7'h14;
    localparam logic [6:0]  LINE_STRIDE_4   = 7'h20;
    localparam logic [5:0]  SHIFT_MAX       = 6'h27;
    localparam int          NUM_LINES       = 4;
    localparam logic [3:0]  BASE_EXEC_CYC   = 4'h5;
    localparam logic [3:0]  WIDE_EXEC_CYC   = 4'h6;
    // opcode masks and matches
    localparam logic [7:0]  OP_CLEAR        = 8'h01;
    localparam logic [7:0]  MASK_HOME       = 8'hfe;
    localparam logic [7:0]  OP_HOME         = 8'h02;
    localparam logic [7:0]  MASK_ENTRY      = 8'hfc;
    localparam logic [7:0]  OP_ENTRY        = 8'h04;
    localparam logic [7:0]  MASK_DISP       = 8'hf8;
    localparam logic [7:0]  OP_DISP         = 8'h08;
    localparam logic [7:0]  MASK_SHIFT      = 8'hf0;
    localparam logic [7:0]  OP_SHIFT        = 8'h10;
    localparam logic [7:0]  MASK_FUNC       = 8'he0;
    localparam logic [7:0]  OP_FUNC         = 8'h20;
    localparam logic [7:0]  OP_SEG_CFG     = 8'hda;
    // reset values
    localparam logic        RST_SEG_ODDEVEN = 1'b1;
    localparam logic        RST_SEG_SWAP    = 1'b0;
    localparam logic        RST_DIR         = 1'b1;
    // field positions
    localparam int          BIT_FUNC_N      = 3;
    localparam int          BIT_FUNC_DH     = 2;
    localparam int          BIT_FUNC_RE     = 1;
    localparam int          BIT_FUNC_IS     = 0;
    localparam int          BIT_SEG_OE      = 4;
    localparam int          BIT_SEG_SW      = 5;
endpackage : oled_cmd_pkg

// file: tb.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
module tb;
    import oled_cmd_pkg::*;
    logic clk_in, srst_in, wr_in, rd_in, data_sel_in, glyph_access_in, lock_in, ok;
    logic segment_remap_strap_in, strap_use_in, busy_out, cmd_refused_out, clear_busy_out;
    logic [7:0] wdata_in, exec_cycles_in, glyph_row_in, rdata_out;
    logic [5:0] glyph_pixels_out;
    logic [ADDR_W-1:0] address_counter_out;
    logic display_on_out, cursor_on_out, blink_on_out, cursor_invert_out, font_width_out;
    logic wide_line_mode_out, line_count_out, common_direction_out, segment_direction_out;
    logic shift_left_pulse_out, shift_right_pulse_out, double_height_enable_out;
    logic [2:0] seg_map_case_out;
    logic [1:0] dbl_height_format_out;
    logic [NUM_LINES-1:0] char_shift_lines_out, dot_scroll_lines_out;
    logic [23:0] line_shift_out;
    int n_errors, n_tests, n_refused;
    char_oled_fundamental_cmd_decoder dut_u (.*);
    host_model host_u (.clk_in(clk_in), .busy_in(busy_out | clear_busy_out),
        .wr_out(wr_in), .dsel_out(data_sel_in), .byte_out(wdata_in));
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) if (cmd_refused_out === 1'b1) n_refused++;
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic cmd(input logic dc, input logic [7:0] b);
        host_u.send(dc, b, ok);
        chk("handshake", 24'h00_0001, 24'(ok));
        if (ok !== 1'b1) end_of_test();
    endtask : cmd
    task automatic rd_chk(input logic [7:0] e);
        @(posedge clk_in) rd_in <= 1'b1;
        @(posedge clk_in) rd_in <= 1'b0;
        #1 chk("rdata", 24'(e), 24'(rdata_out));
    endtask : rd_chk
    initial begin
        srst_in = 1'b1;
        rd_in = 1'b0;
        glyph_access_in = 1'b0;
        lock_in = 1'b0;
        segment_remap_strap_in = 1'b0;
        strap_use_in = 1'b0;
        exec_cycles_in = 8'h04;
        glyph_row_in = 8'hff;
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        #1;
        chk("dirs", 24'h00_0003, 24'({common_direction_out, segment_direction_out}));
        chk("map", 24'h00_0004, 24'(seg_map_case_out));
        chk("lines", 24'h00_00f0, 24'({char_shift_lines_out, dot_scroll_lines_out}));
        cmd(1'b0, 8'h0f);
        chk("disp", 24'h00_0007, 24'({display_on_out, cursor_on_out, blink_on_out}));
        cmd(1'b0, 8'h0a);
        chk("disp", 24'h00_0002, 24'({display_on_out, cursor_on_out, blink_on_out}));
        $display("test display done");
        cmd(1'b0, 8'h10);
        cmd(1'b0, 8'h18);
        chk("ctr", 24'h00_004f, 24'(address_counter_out));
        chk("shift", 24'h04_1041, line_shift_out);
        cmd(1'b0, 8'h02);
        chk("ctr", 24'h00_0000, 24'(address_counter_out));
        chk("shift", 24'h00_0000, line_shift_out);
        cmd(1'b0, 8'h1c);
        chk("shift", 24'h9e_79e7, line_shift_out);
        $display("test shift done");
        cmd(1'b0, 8'h22);
        cmd(1'b0, 8'h04);
        chk("dirs", 24'h00_0000, 24'({common_direction_out, segment_direction_out}));
        chk("map", 24'h00_0006, 24'(seg_map_case_out));
        cmd(1'b0, 8'h0f);
        chk("ext", 24'h00_0007, 24'({font_width_out, cursor_invert_out, wide_line_mode_out}));
        chk("glyph", 24'h00_003f, 24'(glyph_pixels_out));
        cmd(1'b0, 8'h08);
        chk("glyph", 24'h00_001f, 24'(glyph_pixels_out));
        strap_use_in <= 1'b1;
        segment_remap_strap_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        chk("map", 24'h00_0004, 24'(seg_map_case_out));
        lock_in <= 1'b1;
        cmd(1'b0, 8'h0f);
        chk("refused", 24'h00_0001, 24'(n_refused));
        chk("ext", 24'h00_0000, 24'(font_width_out));
        lock_in <= 1'b0;
        $display("test extended done");
        cmd(1'b0, 8'h79);
        cmd(1'b0, 8'hda);
        cmd(1'b0, 8'h60);
        chk("map", 24'h00_0001, 24'(seg_map_case_out));
        cmd(1'b0, 8'h78);
        cmd(1'b0, 8'h20);
        cmd(1'b0, 8'h04);
        cmd(1'b0, 8'h14);
        cmd(1'b0, 8'h01);
        chk("ctr", 24'h00_0000, 24'(address_counter_out));
        cmd(1'b1, 8'h41);
        chk("ctr", 24'h00_0001, 24'(address_counter_out));
        cmd(1'b0, 8'h04);
        cmd(1'b1, 8'h42);
        chk("ctr", 24'h00_0000, 24'(address_counter_out));
        rd_chk(8'h41);
        rd_chk(8'h20);
        $display("test clear done");
        end_of_test();
    end
endmodule : tb
